/* verilog/dsr_pkg.sv */
// constants for the discriminator start and reject logic
package dsr_pkg;
    // ****************************************************
    // clock and timing
    // ****************************************************
    localparam int CLK_NS = 4;
    localparam int STROBE_NS = 50;
    localparam int RUNDOWN_NS = 600;
    localparam int STROBE_CYC_I = (STROBE_NS / CLK_NS) < 1 ? 1 :
        (STROBE_NS / CLK_NS);
    localparam int RUNDOWN_CYC_I = (RUNDOWN_NS / CLK_NS) < 1 ? 1 :
        (RUNDOWN_NS / CLK_NS);
    localparam logic [7:0] STROBE_CYC = STROBE_CYC_I[7:0];
    localparam logic [7:0] RUNDOWN_CYC = RUNDOWN_CYC_I[7:0];

    // ****************************************************
    // synchroniser bit positions
    // ****************************************************
    localparam int NSYNC = 5;
    localparam int SB_LTH = 0;
    localparam int SB_UTH = 1;
    localparam int SB_ZERO = 2;
    localparam int SB_PK = 3;
    localparam int SB_CBUSY = 4;

    // ****************************************************
    // register map
    // ****************************************************
    localparam int AW = 8;
    localparam logic [AW-1:0] CTRL_OFS = 8'h00;
    localparam logic [AW-1:0] STATUS_OFS = 8'h04;
    localparam logic [AW-1:0] CONV_CNT_OFS = 8'h08;
    localparam logic [AW-1:0] REJ_CNT_OFS = 8'h0c;
    localparam int CTRL_ANALYZE_BIT = 0;
    localparam logic CTRL_ANALYZE_RST = 1'b1;
    localparam int ST_DEAD = 0;
    localparam int ST_CLAMP = 1;
    localparam int ST_REJECT = 2;
    localparam int ST_SHUNT = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_RUNDOWN = 5;
    localparam int ST_SUPPRESS = 6;
    localparam int ST_ZERO = 7;
    localparam logic [15:0] CNT_RST = 16'h0000;
endpackage : dsr_pkg

/* verilog/dsr_sync_if.sv */
// bundle between the raw asynchronous inputs and the synchroniser
`timescale 1ns/1ps
`default_nettype none
interface dsr_sync_if;
    logic [dsr_pkg::NSYNC-1:0] raw;
    logic [dsr_pkg::NSYNC-1:0] synced;
    modport src (output raw, input synced);
    modport sync (input raw, output synced);
endinterface : dsr_sync_if
`default_nettype wire

/* verilog/dsr_sync.sv */
// two-stage synchroniser for the comparator and strobe inputs
`timescale 1ns/1ps
`default_nettype none
module dsr_sync (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    dsr_sync_if.sync sif // raw in, synced out
);
    logic [dsr_pkg::NSYNC-1:0] meta_r;
    logic [dsr_pkg::NSYNC-1:0] sync_r;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= sif.raw;
            sync_r <= meta_r;
        end
    end

    assign sif.synced = sync_r;
endmodule : dsr_sync
`default_nettype wire

/* verilog/dsr_ctrl.sv */
// start and reject control of the stretcher converter, with apb registers
// ****************************************************
// Overview of operation
// - dead time is lower threshold or busy
// - clamp released during dead time and busy
// - peak strobe passes only with lower threshold
// - upper threshold sets the reject latch
// - reject latch engages low-impedance stretcher shunt
// - reject latch clears only when dead time ends
// - reject latch blocks the qualified strobe
// - late reject resets busy, suppresses store
// - zero level low holds busy cleared
// - busy sets only with zero level high
// - rundown starts 0.6 us after busy
// - zero level fall ends busy, closes gate
// - off mode suppresses every conversion start
// - qualified strobe is 48 ns low pulse (12 cycles)
// ****************************************************
`timescale 1ns/1ps
`default_nettype none
module dsr_ctrl (
    input wire logic pclk, // 250 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic lower_threshold_hit, // lower comparator
    input wire logic upper_threshold_hit, // upper comparator
    input wire logic above_zero_level, // zero level comparator
    input wire logic peak_detect, // raw peak-detect pulse
    input wire logic converter_busy, // converter busy flag
    output logic dead_time_flag, // dead time
    output logic clamp_release, // discharge clamp released
    output logic reject_latch, // reject latch
    output logic reject_latch_n, // reject latch inverted
    output logic reject_shunt, // low-impedance shunt on
    output logic qualified_peak_strobe_n, // start pulse, low active
    output logic stretcher_busy, // stretcher busy flip-flop
    output logic scaler_gate, // address scaler clock gate open
    output logic rundown_start, // linear rundown on
    output logic internal_reset, // one-cycle busy reset request
    output logic store_suppress // store command suppressed
);
    // ****************************************************
    // synchronised inputs
    // ****************************************************
    dsr_sync_if sif ();
    logic s_lth, s_uth, s_zero, s_pk, s_cbusy;
    assign sif.raw = {converter_busy, peak_detect, above_zero_level,
                      upper_threshold_hit, lower_threshold_hit};
    dsr_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    assign s_lth = sif.synced[dsr_pkg::SB_LTH];
    assign s_uth = sif.synced[dsr_pkg::SB_UTH];
    assign s_zero = sif.synced[dsr_pkg::SB_ZERO];
    assign s_pk = sif.synced[dsr_pkg::SB_PK];
    assign s_cbusy = sif.synced[dsr_pkg::SB_CBUSY];
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hffff) ? v : 16'(v + 16'h0001);
    endfunction : sat_inc

    logic dead_time_flag_r, clamp_release_r, reject_latch_r;
    logic reject_latch_n_r, reject_shunt_r, strobe_n_r;
    logic stretcher_busy_r, scaler_gate_r, rundown_r;
    logic internal_reset_r, store_suppress_r;
    logic analyze_en_r, pk_d_r;
    logic [7:0] strobe_cnt_r, rd_cnt_r;
    logic [15:0] conv_cnt_r, rej_cnt_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic pk_rise, qual, late_reject;

    // ****************************************************
    // dead time and clamp
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dead_time_flag_r <= 1'b0;
            clamp_release_r <= 1'b0;
        end else begin
            dead_time_flag_r <= s_lth | s_cbusy;
            clamp_release_r <= s_lth | s_cbusy;
        end
    end

    // ****************************************************
    // reject latch
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject_latch_r <= 1'b0;
            reject_latch_n_r <= 1'b1;
            reject_shunt_r <= 1'b0;
        end else begin
            if (s_uth) begin
                reject_latch_r <= 1'b1;
                reject_latch_n_r <= 1'b0;
            end else if (!dead_time_flag_r) begin
                reject_latch_r <= 1'b0;
                reject_latch_n_r <= 1'b1;
            end
            reject_shunt_r <= reject_latch_r;
        end
    end

    // ****************************************************
    // peak strobe qualification
    // ****************************************************
    assign pk_rise = s_pk & ~pk_d_r;
    assign qual = pk_rise & s_lth & ~reject_latch_r & s_zero & analyze_en_r;
    assign late_reject = stretcher_busy_r & reject_latch_r & s_zero;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pk_d_r <= 1'b0;
            strobe_cnt_r <= 8'h00;
            strobe_n_r <= 1'b1;
        end else begin
            pk_d_r <= s_pk;
            if (qual) begin
                strobe_cnt_r <= dsr_pkg::STROBE_CYC;
                strobe_n_r <= 1'b0;
            end else if (strobe_cnt_r > 8'h01) begin
                strobe_cnt_r <= 8'(strobe_cnt_r - 8'h01);
            end else begin
                strobe_cnt_r <= 8'h00;
                strobe_n_r <= 1'b1;
            end
        end
    end

    // ****************************************************
    // stretcher busy, gate and rundown
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stretcher_busy_r <= 1'b0;
            scaler_gate_r <= 1'b0;
        end else begin
            if (!s_zero) begin
                stretcher_busy_r <= 1'b0;
            end else if (late_reject) begin
                stretcher_busy_r <= 1'b0;
            end else if (qual) begin
                stretcher_busy_r <= 1'b1;
            end
            scaler_gate_r <= stretcher_busy_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_cnt_r <= 8'h00;
            rundown_r <= 1'b0;
        end else begin
            if (!stretcher_busy_r) begin
                rd_cnt_r <= 8'h00;
                rundown_r <= 1'b0;
            end else if (rd_cnt_r != dsr_pkg::RUNDOWN_CYC) begin
                rd_cnt_r <= 8'(rd_cnt_r + 8'h01);
            end else begin
                rundown_r <= 1'b1;
            end
        end
    end

    // ****************************************************
    // late reject handling
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_reset_r <= 1'b0;
            store_suppress_r <= 1'b0;
        end else begin
            internal_reset_r <= late_reject;
            if (late_reject) begin
                store_suppress_r <= 1'b1;
            end else if (!reject_latch_r) begin
                store_suppress_r <= 1'b0;
            end
        end
    end

    // ****************************************************
    // apb registers
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cnt_r <= dsr_pkg::CNT_RST;
            rej_cnt_r <= dsr_pkg::CNT_RST;
        end else begin
            if (qual) begin
                conv_cnt_r <= sat_inc(conv_cnt_r);
            end
            if (late_reject) begin
                rej_cnt_r <= sat_inc(rej_cnt_r);
            end
        end
    end

    logic acc, mapped;
    logic [31:0] rd_val;
    assign acc = psel & penable & ~pready_r;
    assign mapped = (paddr == dsr_pkg::CTRL_OFS) ||
                    (paddr == dsr_pkg::STATUS_OFS) ||
                    (paddr == dsr_pkg::CONV_CNT_OFS) ||
                    (paddr == dsr_pkg::REJ_CNT_OFS);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            dsr_pkg::CTRL_OFS: begin
                rd_val[dsr_pkg::CTRL_ANALYZE_BIT] = analyze_en_r;
            end
            dsr_pkg::STATUS_OFS: begin
                rd_val[dsr_pkg::ST_DEAD] = dead_time_flag_r;
                rd_val[dsr_pkg::ST_CLAMP] = clamp_release_r;
                rd_val[dsr_pkg::ST_REJECT] = reject_latch_r;
                rd_val[dsr_pkg::ST_SHUNT] = reject_shunt_r;
                rd_val[dsr_pkg::ST_BUSY] = stretcher_busy_r;
                rd_val[dsr_pkg::ST_RUNDOWN] = rundown_r;
                rd_val[dsr_pkg::ST_SUPPRESS] = store_suppress_r;
                rd_val[dsr_pkg::ST_ZERO] = s_zero;
            end
            dsr_pkg::CONV_CNT_OFS: rd_val = {16'h0000, conv_cnt_r};
            dsr_pkg::REJ_CNT_OFS: rd_val = {16'h0000, rej_cnt_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            analyze_en_r <= dsr_pkg::CTRL_ANALYZE_RST;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc & ~mapped;
            prdata_r <= (acc && !pwrite) ? rd_val : 32'h0000_0000;
            if (psel && penable && pready_r && pwrite &&
                paddr == dsr_pkg::CTRL_OFS) begin
                analyze_en_r <= pwdata[dsr_pkg::CTRL_ANALYZE_BIT];
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign dead_time_flag = dead_time_flag_r;
    assign clamp_release = clamp_release_r;
    assign reject_latch = reject_latch_r;
    assign reject_latch_n = reject_latch_n_r;
    assign reject_shunt = reject_shunt_r;
    assign qualified_peak_strobe_n = strobe_n_r;
    assign stretcher_busy = stretcher_busy_r;
    assign scaler_gate = scaler_gate_r;
    assign rundown_start = rundown_r;
    assign internal_reset = internal_reset_r;
    assign store_suppress = store_suppress_r;

    // ****************************************************
    // assertions
    // ****************************************************
    property p_dead_time;
        @(posedge pclk) disable iff (!presetn)
        (s_lth || s_cbusy) |=> dead_time_flag_r;
    endproperty
    a_dead_time: assert property (p_dead_time)
        else $error("dead time missed");
    property p_clamp;
        @(posedge pclk) disable iff (!presetn)
        !(s_lth || s_cbusy) |=> !clamp_release_r;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("clamp not engaged");
    property p_reject_set;
        @(posedge pclk) disable iff (!presetn)
        s_uth |=> reject_latch_r && !reject_latch_n_r ##1 reject_shunt_r;
    endproperty
    a_reject_set: assert property (p_reject_set)
        else $error("reject latch or shunt missed");
    property p_reject_hold;
        @(posedge pclk) disable iff (!presetn)
        reject_latch_r && dead_time_flag_r |=> reject_latch_r;
    endproperty
    a_reject_hold: assert property (p_reject_hold)
        else $error("reject cleared during dead time");
    property p_no_start;
        @(posedge pclk) disable iff (!presetn)
        (reject_latch_r || !analyze_en_r || !s_lth) && !stretcher_busy_r
            |=> !stretcher_busy_r;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("conversion started while blocked");
    property p_late_reject;
        @(posedge pclk) disable iff (!presetn)
        late_reject |=> !stretcher_busy_r && internal_reset_r
            && store_suppress_r;
    endproperty
    a_late_reject: assert property (p_late_reject)
        else $error("late reject not handled");
    property p_zero_clear;
        @(posedge pclk) disable iff (!presetn)
        !s_zero |=> !stretcher_busy_r ##1 !scaler_gate_r;
    endproperty
    a_zero_clear: assert property (p_zero_clear)
        else $error("busy or gate held with zero level low");
    property p_rundown;
        @(posedge pclk) disable iff (!presetn)
        $rose(rundown_r) |-> $past(stretcher_busy_r, 150);
    endproperty
    a_rundown: assert property (p_rundown)
        else $error("rundown started early");
    sequence s_strobe_start;
        $fell(strobe_n_r) && stretcher_busy_r;
    endsequence
    property p_strobe;
        @(posedge pclk) disable iff (!presetn)
        $fell(strobe_n_r) |-> s_strobe_start ##1 !strobe_n_r[*8];
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("start pulse too short or busy not set");
endmodule : dsr_ctrl
`default_nettype wire

/* test/dsr_analog_model.sv */
// behavioural comparators and stretcher facing the start and reject logic
`timescale 1ns/1ps
`default_nettype none
module dsr_analog_model #(
    parameter int LOWER_MV = 500,
    parameter int UPPER_MV = 3000
) (
    input wire logic pclk, // system clock
    input wire logic fire, // launch one shaped input pulse
    input wire logic [15:0] amp, // pulse peak in millivolts
    input wire logic pile, // add a late pile-up pulse
    input wire logic [15:0] zero_set, // zero level bias in millivolts
    input wire logic clamp_release, // discharge clamp off
    input wire logic reject_shunt, // low-impedance shunt on
    input wire logic rundown_start, // linear discharge on
    output var logic lower_threshold_hit, // lower comparator
    output var logic upper_threshold_hit, // upper comparator
    output var logic above_zero_level, // stretcher above zero bias
    output var logic peak_detect // raw peak-detect pulse
);
    int ph = 60;
    int vin;
    int vcap = 0;

    // ****************************************************
    // input pulse, stretcher and comparators
    // ****************************************************
    always_comb begin
        vin = ph <= 20 ? amp * ph / 20 : ph <= 40 ? amp * (40 - ph) / 20 : 0;
        if (pile && ph >= 30 && ph < 45)
            vin = vin + 6000;
    end

    initial begin
        lower_threshold_hit = 1'b0;
        upper_threshold_hit = 1'b0;
        above_zero_level = 1'b0;
        peak_detect = 1'b0;
    end

    always @(posedge pclk) begin
        ph <= fire ? 0 : (ph < 60 ? ph + 1 : 60);
        // either shunt makes the held voltage follow the input down
        if (reject_shunt || !clamp_release || vin > vcap)
            vcap <= vin;
        else if (rundown_start)
            vcap <= vcap > 20 ? vcap - 20 : 0;
        lower_threshold_hit <= vin > LOWER_MV;
        upper_threshold_hit <= vin > UPPER_MV;
        above_zero_level <= vcap > zero_set;
        peak_detect <= ph >= 21 && ph < 33;
    end
endmodule : dsr_analog_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the start and reject logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, (a), (e)); end end
`define WAITV(c) begin int k; k = 0; \
    while ((c) !== 1'b1 && k < 3000) begin @(negedge pclk); k++; end \
    if ((c) !== 1'b1) begin bad_count++; report_and_stop(); end end
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, er, dead_time_flag, clamp_release;
    logic reject_latch, reject_latch_n, reject_shunt, scaler_gate;
    logic qualified_peak_strobe_n, stretcher_busy, rundown_start;
    logic internal_reset, store_suppress, lower_threshold_hit;
    logic upper_threshold_hit, above_zero_level, peak_detect;
    logic converter_busy = 1'b0;
    logic fire = 1'b0, pile = 1'b0, auto_busy = 1'b1, man_busy = 1'b0;
    logic [15:0] amp = 16'h0000, zero_set = 16'h0064;
    int bad_count = 0, checks_done = 0, n, lo;

    always #2 pclk = ~pclk;
    // the bench plays the converter: busy follows the stretcher, or man_busy when auto_busy is low
    always @(posedge pclk) begin
        converter_busy <= auto_busy ? stretcher_busy : man_busy;
    end

    dsr_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .lower_threshold_hit,
        .upper_threshold_hit, .above_zero_level, .peak_detect,
        .converter_busy, .dead_time_flag, .clamp_release, .reject_latch,
        .reject_latch_n, .reject_shunt, .qualified_peak_strobe_n,
        .stretcher_busy, .scaler_gate, .rundown_start, .internal_reset,
        .store_suppress);
    dsr_analog_model model (.pclk, .fire, .amp, .pile, .zero_set,
        .clamp_release, .reject_shunt, .rundown_start, .lower_threshold_hit,
        .upper_threshold_hit, .above_zero_level, .peak_detect);

    // ****************************************************
    // tasks
    // ****************************************************
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 50 && pready !== 1'b1; i++) @(posedge pclk);
        if (pready !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        d = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
        input logic ee);
        apb(1'b0, a, 32'h0);
        `CHK(d, e)
        `CHK(er, ee)
    endtask : rdc

    task automatic shoot(input logic [15:0] a, input logic p,
        input logic [15:0] z);
        @(posedge pclk);
        amp <= a;
        pile <= p;
        zero_set <= z;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
    endtask : shoot

    task automatic settle();
        repeat (70) @(negedge pclk);
        `WAITV(!stretcher_busy && !dead_time_flag && !reject_latch)
    endtask : settle

    task report_and_stop();
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // ****************************************************
    // sequence
    // ****************************************************
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        `CHK(reject_latch_n, 1'b1)
        `CHK(qualified_peak_strobe_n, 1'b1)
        rdc(dsr_pkg::CTRL_OFS, 32'h1, 1'b0);
        apb(1'b1, dsr_pkg::STATUS_OFS, 32'hffffffff);
        rdc(dsr_pkg::STATUS_OFS, 32'h0, 1'b0);
        rdc(8'h10, 32'h0, 1'b1);
        shoot(16'h07d0, 1'b0, 16'h0064);
        `WAITV(lower_threshold_hit)
        n = 0;
        while (dead_time_flag !== 1'b1 && n < 9) begin
            @(negedge pclk);
            n++;
        end
        `CHK(n, 3)
        `CHK(clamp_release, 1'b1)
        `WAITV(stretcher_busy)
        n = 0;
        lo = 0;
        while (rundown_start !== 1'b1 && n < 400) begin
            lo += (qualified_peak_strobe_n === 1'b0);
            @(negedge pclk);
            n++;
        end
        `CHK(n, dsr_pkg::RUNDOWN_CYC_I + 1)
        `CHK(lo, dsr_pkg::STROBE_CYC_I)
        `CHK(scaler_gate, 1'b1)
        `WAITV(!stretcher_busy)
        `CHK(scaler_gate, 1'b1)
        `CHK(rundown_start, 1'b1)
        @(negedge pclk);
        `CHK(scaler_gate, 1'b0)
        `CHK(rundown_start, 1'b0)
        settle();
        rdc(dsr_pkg::CONV_CNT_OFS, 32'h1, 1'b0);
        // below lower level, below zero level, then off mode
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, dsr_pkg::CTRL_OFS, {31'h0, c != 2});
            shoot(c == 0 ? 16'h012c : 16'h07d0, 1'b0,
                c == 1 ? 16'h0bb8 : 16'h0064);
            settle();
            rdc(dsr_pkg::CONV_CNT_OFS, 32'h1, 1'b0);
        end
        apb(1'b1, dsr_pkg::CTRL_OFS, 32'h1);
        auto_busy <= 1'b0;
        man_busy <= 1'b1;
        shoot(16'h1770, 1'b0, 16'h0064);
        `WAITV(reject_latch)
        `CHK(reject_latch_n, 1'b0)
        @(negedge pclk);
        `CHK(reject_shunt, 1'b1)
        repeat (70) @(negedge pclk);
        `CHK(reject_latch, 1'b1)
        rdc(dsr_pkg::STATUS_OFS, 32'hf, 1'b0);
        rdc(dsr_pkg::CONV_CNT_OFS, 32'h1, 1'b0);
        man_busy <= 1'b0;
        settle();
        `CHK(reject_shunt, 1'b0)
        auto_busy <= 1'b1;
        shoot(16'h07d0, 1'b1, 16'h0064);
        `WAITV(internal_reset)
        `CHK(stretcher_busy, 1'b0)
        @(negedge pclk);
        `CHK(internal_reset, 1'b0)
        `CHK(store_suppress, 1'b1)
        settle();
        `CHK(store_suppress, 1'b0)
        rdc(dsr_pkg::CONV_CNT_OFS, 32'h2, 1'b0);
        rdc(dsr_pkg::REJ_CNT_OFS, 32'h1, 1'b0);
        report_and_stop();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        bad_count++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
